/* hw/core_arch_regs_user_port.sv */
// Architectural core registers and nine-pin user port with its latches and directions
//
// Behaviour
// - Flag bits 4:3 choose working register bank
// - Parity flag tracks accumulator one-bit count
// - User flags change only by software writes
// - Stack pointer is eight bits, resets 0x07
// - Stack pointer increments before push store
// - Sixteen-bit pointer, loadable whole or bytewise
// - Pointer addresses indexed code and external data
// - Program counter sixteen bits, resets 0x0000
// - Program counter advances on fetch and operand
// - Program counter has no register address
// - Accumulator operand holder; aux for multiply/divide
// - Output pin follows its written latch bit
// - Low latch 0x90 pins 0-7, direction 0x91
// - Ninth pin latch 0xA0, direction 0xA1
// - Direction bit zero makes pin output
// - Every pin bidirectional unless alternate function claims
`default_nettype none
module core_arch_regs_user_port
(
  input  wire logic                      CLOCK,
  input  wire logic                      RST_N,
  input  wire core_regs_pkg::sfr_req_type SFR_REQ,
  output logic [7:0]                     SFR_RDATA,
  output logic                           SFR_RVALID,
  input  wire logic                      STACK_PUSH,
  input  wire logic                      STACK_POP,
  output logic [7:0]                     STACK_TOP,
  input  wire logic                      POINTER_LOAD,
  input  wire logic [15:0]               POINTER_VALUE,
  input  wire logic                      ADDR_INDEXED,
  output logic [15:0]                    EXT_ADDR,
  input  wire logic                      PC_ADVANCE,
  input  wire logic                      PC_LOAD,
  input  wire logic [15:0]               PC_VALUE,
  output logic [15:0]                    PROGRAM_COUNTER,
  input  wire logic                      ACC_WR,
  input  wire logic [7:0]                ACC_VALUE,
  input  wire logic                      AUX_WR,
  input  wire logic [7:0]                AUX_VALUE,
  input  wire core_regs_pkg::alu_flags_type ALU_FLAGS,
  output logic [7:0]                     MAIN_OPERAND,
  output logic [7:0]                     AUX_OPERAND,
  output logic [7:0]                     FLAGS_WORD,
  output logic [7:0]                     BANK_BASE,
  input  wire logic [8:0]                ALT_CLAIM,
  input  wire logic [8:0]                USER_PIN_IN,
  output logic [8:0]                     USER_PIN_OUT,
  output logic [8:0]                     USER_PIN_OE
);

  // ****************************************
  // State of the block
  // ****************************************
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  aux;
    logic [7:0]  flags;
    logic [7:0]  sp;
    logic [15:0] external_address_pointer;
    logic [15:0] pc;
    logic [7:0]  latch_low;
    logic [7:0]  dir_low;
    logic [7:0]  latch_ninth;
    logic [7:0]  dir_ninth;
    logic [8:0]  pin_meta;
    logic [8:0]  pin_sync;
    logic [8:0]  pin_oe;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic [15:0] ext_addr;
    logic [7:0]  bank_base;
  } state_type;

  localparam state_type RESET_STATE = '{
    acc:         core_regs_pkg::OPERAND_RESET,
    aux:         core_regs_pkg::OPERAND_RESET,
    flags:       core_regs_pkg::PROCESSOR_FLAGS_WORD_RESET,
    sp:          core_regs_pkg::STACK_TOP_POINTER_RESET,
    external_address_pointer:        core_regs_pkg::EXTERNAL_POINTER_RESET,
    pc:          core_regs_pkg::PROGRAM_COUNTER_RESET,
    latch_low:   core_regs_pkg::USER_PORT_LATCH_LOW_RESET,
    dir_low:     core_regs_pkg::USER_PORT_DIRECTION_LOW_RESET,
    latch_ninth: core_regs_pkg::USER_PORT_LATCH_NINTH_RESET,
    dir_ninth:   core_regs_pkg::USER_PORT_DIRECTION_NINTH_RESET,
    pin_meta:    9'h000,
    pin_sync:    9'h000,
    pin_oe:      9'h000,
    rd_data:     core_regs_pkg::UNMAPPED_READ_VALUE,
    rd_valid:    1'b0,
    ext_addr:    core_regs_pkg::EXTERNAL_POINTER_RESET,
    bank_base:   8'h00
  };

  state_type state_q;
  state_type state_d;

  // ****************************************
  // Helper functions
  // ****************************************

  // Even parity over a byte: one when the count of ones is odd
  function automatic logic odd_ones(input logic [7:0] value);
    odd_ones = ^value;
  endfunction : odd_ones

  // Per-bit mix of pin level and latch, steered by direction
  function automatic logic [7:0] port_view(input logic [7:0] latch,
                                            input logic [7:0] dir,
                                            input logic [7:0] pins);
    port_view = (dir & pins) | (~dir & latch);
  endfunction : port_view

  // Working bank base address from the two select bits
  function automatic logic [7:0] bank_start(input logic [7:0] flags);
    logic [1:0] sel;
    sel = {flags[core_regs_pkg::BANK_SELECT_HIGH_POS], flags[core_regs_pkg::BANK_SELECT_LOW_POS]};
    bank_start = {3'b000, sel, 3'b000};
  endfunction : bank_start

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    logic [7:0] low_view;
    logic [7:0] ninth_view;
    state_d    = state_q;
    low_view   = 8'h00;
    ninth_view = 8'h00;

    // Pins are asynchronous to the clock; one flop alone could go metastable
    // Pins cross in through two flops; only the second stage is read
    state_d.pin_meta = USER_PIN_IN;
    state_d.pin_sync = state_q.pin_meta;

    low_view   = port_view(state_q.latch_low, state_q.dir_low, state_q.pin_sync[7:0]);
    ninth_view = port_view(state_q.latch_ninth, state_q.dir_ninth, {7'h00, state_q.pin_sync[8]});

    // Software writes over the special function register port
    if (SFR_REQ.wr)
    begin
      unique case (SFR_REQ.addr)
        core_regs_pkg::STACK_TOP_POINTER_ADDR:
          state_d.sp = SFR_REQ.wdata;
        core_regs_pkg::EXTERNAL_POINTER_LOW_ADDR:
          state_d.external_address_pointer[7:0] = SFR_REQ.wdata;
        core_regs_pkg::EXTERNAL_POINTER_HIGH_ADDR:
          state_d.external_address_pointer[15:8] = SFR_REQ.wdata;
        core_regs_pkg::USER_PORT_LATCH_LOW_ADDR:
          state_d.latch_low = SFR_REQ.wdata;
        core_regs_pkg::USER_PORT_DIRECTION_LOW_ADDR:
          state_d.dir_low = SFR_REQ.wdata;
        core_regs_pkg::USER_PORT_LATCH_NINTH_ADDR:
          state_d.latch_ninth = SFR_REQ.wdata;
        core_regs_pkg::USER_PORT_DIRECTION_NINTH_ADDR:
          state_d.dir_ninth = SFR_REQ.wdata;
        core_regs_pkg::PROCESSOR_FLAGS_WORD_ADDR:
          state_d.flags[7:1] = SFR_REQ.wdata[7:1];
        core_regs_pkg::MAIN_OPERAND_REGISTER_ADDR:
          state_d.acc = SFR_REQ.wdata;
        core_regs_pkg::AUX_OPERAND_REGISTER_ADDR:
          state_d.aux = SFR_REQ.wdata;
        // Writes elsewhere are dropped rather than trapped
        // no address reaches the program counter
        default:
          state_d.rd_data = state_d.rd_data;
      endcase
    end

    // Register reads answer one cycle later; unmapped reads give zero
    state_d.rd_valid = SFR_REQ.rd;
    if (SFR_REQ.rd)
    begin
      unique case (SFR_REQ.addr)
        core_regs_pkg::STACK_TOP_POINTER_ADDR:         state_d.rd_data = state_q.sp;
        core_regs_pkg::EXTERNAL_POINTER_LOW_ADDR:      state_d.rd_data = state_q.external_address_pointer[7:0];
        core_regs_pkg::EXTERNAL_POINTER_HIGH_ADDR:     state_d.rd_data = state_q.external_address_pointer[15:8];
        core_regs_pkg::USER_PORT_LATCH_LOW_ADDR:       state_d.rd_data = low_view;
        core_regs_pkg::USER_PORT_DIRECTION_LOW_ADDR:   state_d.rd_data = state_q.dir_low;
        core_regs_pkg::USER_PORT_LATCH_NINTH_ADDR:     state_d.rd_data = ninth_view;
        core_regs_pkg::USER_PORT_DIRECTION_NINTH_ADDR: state_d.rd_data = state_q.dir_ninth;
        core_regs_pkg::PROCESSOR_FLAGS_WORD_ADDR:      state_d.rd_data = state_q.flags;
        core_regs_pkg::MAIN_OPERAND_REGISTER_ADDR:     state_d.rd_data = state_q.acc;
        core_regs_pkg::AUX_OPERAND_REGISTER_ADDR:      state_d.rd_data = state_q.aux;
        default:                                       state_d.rd_data = core_regs_pkg::UNMAPPED_READ_VALUE;
      endcase
    end

    // Execution writes come after software ones, so they win a clash
    // operand registers loaded by execution
    if (ACC_WR)
    begin
      state_d.acc = ACC_VALUE;
    end
    if (AUX_WR)
    begin
      state_d.aux = AUX_VALUE;
    end

    // Arithmetic flags; the user flags and bank bits are left alone
    if (ALU_FLAGS.wr)
    begin
      state_d.flags[core_regs_pkg::CARRY_FLAG_POS]      = ALU_FLAGS.carry;
      state_d.flags[core_regs_pkg::HALF_CARRY_FLAG_POS] = ALU_FLAGS.half_carry;
      state_d.flags[core_regs_pkg::SIGNED_EXCESS_POS]   = ALU_FLAGS.signed_excess;
    end

    // parity follows the next accumulator value
    state_d.flags[core_regs_pkg::PARITY_FLAG_POS] = odd_ones(state_d.acc);

    // No overflow guard: the pointer wraps, keeping the stack in range is up to software
    // pre-increment on push, post-decrement on pop
    if (STACK_PUSH)
    begin
      state_d.sp = state_q.sp + 8'h01;
    end
    else if (STACK_POP)
    begin
      state_d.sp = state_q.sp - 8'h01;
    end

    if (POINTER_LOAD)
    begin
      state_d.external_address_pointer = POINTER_VALUE;
    end

    // advance on fetch, jump load takes priority
    if (PC_LOAD)
    begin
      state_d.pc = PC_VALUE;
    end
    else if (PC_ADVANCE)
    begin
      state_d.pc = state_q.pc + 16'h0001;
    end

    if (ADDR_INDEXED)
    begin
      // Sum cut to sixteen bits; indexing past the top wraps to zero
      state_d.ext_addr = 16'(state_d.external_address_pointer + {8'h00, state_d.acc});
    end
    else
    begin
      state_d.ext_addr = state_d.external_address_pointer;
    end

    state_d.bank_base = bank_start(state_d.flags);

    // Claim only removes drive; the read path still follows direction and latch
    // direction zero drives; alternate claim releases pin
    state_d.pin_oe = ~{state_d.dir_ninth[0], state_d.dir_low} & ~ALT_CLAIM;
  end

  // ****************************************
  // State register
  // ****************************************

  // Synchronous reset; every field has a constant reset value
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state_q <= RESET_STATE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs, all straight from flops
  // ****************************************
  assign SFR_RDATA       = state_q.rd_data;
  assign SFR_RVALID      = state_q.rd_valid;
  assign STACK_TOP       = state_q.sp;
  assign EXT_ADDR        = state_q.ext_addr;
  assign PROGRAM_COUNTER = state_q.pc;
  assign MAIN_OPERAND    = state_q.acc;
  assign AUX_OPERAND     = state_q.aux;
  assign FLAGS_WORD      = state_q.flags;
  assign BANK_BASE       = state_q.bank_base;
  assign USER_PIN_OUT    = {state_q.latch_ninth[0], state_q.latch_low};
  assign USER_PIN_OE     = state_q.pin_oe;

endmodule : core_arch_regs_user_port
`default_nettype wire

/* hw/core_regs_pkg.sv */
// Package: addresses, reset values and carrier types of the core register block
`default_nettype none
package core_regs_pkg;

  // ****************************************
  // Special function register addresses
  // ****************************************
  localparam logic [7:0] STACK_TOP_POINTER_ADDR         = 8'h81;
  localparam logic [7:0] EXTERNAL_POINTER_LOW_ADDR      = 8'h82;
  localparam logic [7:0] EXTERNAL_POINTER_HIGH_ADDR     = 8'h83;
  localparam logic [7:0] USER_PORT_LATCH_LOW_ADDR       = 8'h90;
  localparam logic [7:0] USER_PORT_DIRECTION_LOW_ADDR   = 8'h91;
  localparam logic [7:0] USER_PORT_LATCH_NINTH_ADDR     = 8'ha0;
  localparam logic [7:0] USER_PORT_DIRECTION_NINTH_ADDR = 8'ha1;
  localparam logic [7:0] PROCESSOR_FLAGS_WORD_ADDR      = 8'hd0;
  localparam logic [7:0] MAIN_OPERAND_REGISTER_ADDR     = 8'he0;
  localparam logic [7:0] AUX_OPERAND_REGISTER_ADDR      = 8'hf0;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [7:0]  STACK_TOP_POINTER_RESET         = 8'h07;
  localparam logic [15:0] EXTERNAL_POINTER_RESET          = 16'h0000;
  localparam logic [15:0] PROGRAM_COUNTER_RESET           = 16'h0000;
  localparam logic [7:0]  OPERAND_RESET                   = 8'h00;
  localparam logic [7:0]  PROCESSOR_FLAGS_WORD_RESET      = 8'h00;
  localparam logic [7:0]  USER_PORT_LATCH_LOW_RESET       = 8'hff;
  localparam logic [7:0]  USER_PORT_DIRECTION_LOW_RESET   = 8'hff;
  localparam logic [7:0]  USER_PORT_LATCH_NINTH_RESET     = 8'h00;
  localparam logic [7:0]  USER_PORT_DIRECTION_NINTH_RESET = 8'h01;
  localparam logic [7:0]  UNMAPPED_READ_VALUE             = 8'h00;

  // ****************************************
  // Flag word bit positions and bank layout
  // ****************************************
  localparam int CARRY_FLAG_POS        = 7;
  localparam int HALF_CARRY_FLAG_POS   = 6;
  localparam int USER_FLAG_ZERO_POS    = 5;
  localparam int BANK_SELECT_HIGH_POS  = 4;
  localparam int BANK_SELECT_LOW_POS   = 3;
  localparam int SIGNED_EXCESS_POS     = 2;
  localparam int USER_FLAG_ONE_POS     = 1;
  localparam int PARITY_FLAG_POS       = 0;
  localparam int BANK_BASE_SHIFT       = 3;
  localparam int USER_PIN_COUNT        = 9;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic wr;
    logic carry;
    logic half_carry;
    logic signed_excess;
  } alu_flags_type;

endpackage : core_regs_pkg
`default_nettype wire

/* tb/core_regs_sva.sv */
// Port checker for the core register block
`default_nettype none
module core_regs_sva
(
  input wire logic                       CLOCK,
  input wire logic                       RST_N,
  input wire core_regs_pkg::sfr_req_type SFR_REQ,
  input wire logic                       STACK_PUSH,
  input wire logic [7:0]                 STACK_TOP,
  input wire logic                       POINTER_LOAD,
  input wire logic                       ADDR_INDEXED,
  input wire logic [15:0]                EXT_ADDR,
  input wire logic                       PC_ADVANCE,
  input wire logic                       PC_LOAD,
  input wire logic [15:0]                PROGRAM_COUNTER,
  input wire logic                       ACC_WR,
  input wire logic [7:0]                 MAIN_OPERAND,
  input wire logic [7:0]                 FLAGS_WORD,
  input wire logic [7:0]                 BANK_BASE,
  input wire logic [8:0]                 ALT_CLAIM,
  input wire logic [8:0]                 USER_PIN_OUT,
  input wire logic [8:0]                 USER_PIN_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Relations between the ports
  // ********
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  bank_base_a : assert property (BANK_BASE == {3'b000, FLAGS_WORD[4:3], 3'b000})
    else $error("bank base does not follow flag bits");
  parity_flag_a : assert property (FLAGS_WORD[0] == ^MAIN_OPERAND)
    else $error("parity flag wrong");
  user_flags_a : assert property (!(SFR_REQ.wr && SFR_REQ.addr == 8'hd0) |=> $stable({FLAGS_WORD[5], FLAGS_WORD[1]}))
    else $error("user flag changed without write");
  // Reset itself is the antecedent here, so disabling on it is switched off
  reset_values_a : assert property (disable iff (1'b0) !RST_N |=> STACK_TOP == 8'h07 && PROGRAM_COUNTER == 16'h0000)
    else $error("reset values wrong");
  push_inc_a : assert property (STACK_PUSH |=> STACK_TOP == $past(STACK_TOP) + 8'h01)
    else $error("push did not pre-increment");
  pc_advance_a : assert property (PC_ADVANCE && !PC_LOAD |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 16'h0001)
    else $error("counter did not advance");
  indexed_addr_a : assert property ($rose(ADDR_INDEXED) && !ACC_WR && !POINTER_LOAD && !SFR_REQ.wr
    |=> EXT_ADDR == $past(EXT_ADDR) + {8'h00, MAIN_OPERAND})
    else $error("indexed address wrong");
  latch_pins_a : assert property (SFR_REQ.wr && SFR_REQ.addr == 8'h90 |=> USER_PIN_OUT[7:0] == $past(SFR_REQ.wdata))
    else $error("pins do not follow latch");
  claim_drive_a : assert property (1'b1 |=> (USER_PIN_OE & $past(ALT_CLAIM)) == 9'h000)
    else $error("claimed pin still driven");

  cover property (STACK_PUSH);
  cover property ($rose(ADDR_INDEXED));
  cover property (|ALT_CLAIM);
endmodule : core_regs_sva

bind core_arch_regs_user_port core_regs_sva chk
(
  .CLOCK(CLOCK), .RST_N(RST_N), .SFR_REQ(SFR_REQ), .STACK_PUSH(STACK_PUSH), .STACK_TOP(STACK_TOP),
  .POINTER_LOAD(POINTER_LOAD), .ADDR_INDEXED(ADDR_INDEXED), .EXT_ADDR(EXT_ADDR), .PC_ADVANCE(PC_ADVANCE),
  .PC_LOAD(PC_LOAD), .PROGRAM_COUNTER(PROGRAM_COUNTER), .ACC_WR(ACC_WR), .MAIN_OPERAND(MAIN_OPERAND),
  .FLAGS_WORD(FLAGS_WORD), .BANK_BASE(BANK_BASE), .ALT_CLAIM(ALT_CLAIM), .USER_PIN_OUT(USER_PIN_OUT),
  .USER_PIN_OE(USER_PIN_OE)
);
`default_nettype wire

/* tb/user_pin_model.sv */
// Far side of the nine user pins
`default_nettype none
module user_pin_model
(
  input wire logic [8:0] pin_oe,
  input wire logic [8:0] pin_out,
  input wire logic [8:0] far_value,
  output logic [8:0]     pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // shared pin level
  // Device drive wins; elsewhere the far side holds the line
  always_comb
  begin
    pin_level = (pin_oe & pin_out) | (~pin_oe & far_value);
  end
endmodule : user_pin_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the core register block
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Stimulus and observed signals
  // ********
  logic                         clock = 1'b0;
  logic                         rst_n = 1'b0;
  logic                         push = 1'b0, pop = 1'b0, pload = 1'b0, idx = 1'b0;
  logic                         adv = 1'b0, pcld = 1'b0, accw = 1'b0, auxw = 1'b0;
  logic [7:0]                   accv = 8'h00, auxv = 8'h00;
  logic [8:0]                   claim = 9'h000;
  logic [8:0]                   far = 9'h13c;
  logic [15:0]                  pv = 16'h0000, pcv = 16'h0000;
  core_regs_pkg::sfr_req_type   req = '0;
  core_regs_pkg::alu_flags_type alu = '0;
  logic [7:0]                   rdata, top, acc, aux, flags, bank;
  logic                         rvalid;
  logic [15:0]                  ext, pc;
  logic [8:0]                   pin_in, pin_out, pin_oe;
  int                           mismatches = 0;
  int                           total_checks = 0;
  int                           cycles = 0;

  core_arch_regs_user_port dut
  (
    .CLOCK(clock), .RST_N(rst_n), .SFR_REQ(req), .SFR_RDATA(rdata), .SFR_RVALID(rvalid),
    .STACK_PUSH(push), .STACK_POP(pop), .STACK_TOP(top), .POINTER_LOAD(pload), .POINTER_VALUE(pv),
    .ADDR_INDEXED(idx), .EXT_ADDR(ext), .PC_ADVANCE(adv), .PC_LOAD(pcld), .PC_VALUE(pcv),
    .PROGRAM_COUNTER(pc), .ACC_WR(accw), .ACC_VALUE(accv), .AUX_WR(auxw), .AUX_VALUE(auxv),
    .ALU_FLAGS(alu), .MAIN_OPERAND(acc), .AUX_OPERAND(aux), .FLAGS_WORD(flags), .BANK_BASE(bank),
    .ALT_CLAIM(claim), .USER_PIN_IN(pin_in), .USER_PIN_OUT(pin_out), .USER_PIN_OE(pin_oe)
  );

  user_pin_model pins
  (
    .pin_oe(pin_oe), .pin_out(pin_out), .far_value(far), .pin_level(pin_in)
  );

  // Clock and hang guard; the run needs well under a thousand cycles
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // Register port cycles, one idle edge between requests
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask : rd

  task automatic t_reset;
    `CHK(top, 8'h07)
    `CHK(pc, 16'h0000)
    rd(8'h91, 8'hff);
    rd(8'ha1, 8'h01);
    rd(8'h90, far[7:0]);
  endtask : t_reset

  // Pop in the same cycle as a push must lose
  task automatic t_stack;
    @(posedge clock);
    push <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    `CHK(top, 8'h08)
    @(posedge clock);
    pop <= 1'b1;
    @(posedge clock);
    push <= 1'b0;
    pop <= 1'b0;
    @(negedge clock);
    `CHK(top, 8'h0a)
    // A pop on its own must step the pointer back down
    @(posedge clock);
    pop <= 1'b1;
    @(posedge clock);
    pop <= 1'b0;
    @(negedge clock);
    `CHK(top, 8'h09)
    rd(8'h81, 8'h09);
  endtask : t_stack

  task automatic t_flags;
    for (int b = 0; b < 4; b++)
    begin
      wr(8'hd0, 8'(b << 3));
      `CHK(bank, 8'(b << 3))
    end
    wr(8'hd0, 8'h22);
    @(posedge clock);
    alu <= 4'hf;
    accw <= 1'b1;
    accv <= 8'h07;
    auxw <= 1'b1;
    auxv <= 8'h3c;
    @(posedge clock);
    alu <= '0;
    accw <= 1'b0;
    auxw <= 1'b0;
    @(negedge clock);
    `CHK(flags, 8'he7)
    `CHK(acc, 8'h07)
    `CHK(aux, 8'h3c)
    wr(8'he0, 8'h03);
    `CHK(flags[0], 1'b0)
    wr(8'hf0, 8'h5a);
    rd(8'hf0, 8'h5a);
  endtask : t_flags

  task automatic t_pointer;
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    `CHK(ext, 16'h1234)
    @(posedge clock);
    idx <= 1'b1;
    @(posedge clock);
    pload <= 1'b1;
    pv <= 16'habcd;
    @(negedge clock);
    `CHK(ext, 16'h1237)
    @(posedge clock);
    pload <= 1'b0;
    idx <= 1'b0;
    @(negedge clock);
    `CHK(ext, 16'habd0)
    rd(8'h82, 8'hcd);
  endtask : t_pointer

  // Load must win over a same-cycle advance
  task automatic t_pc;
    @(posedge clock);
    adv <= 1'b1;
    repeat (3) @(posedge clock);
    pcld <= 1'b1;
    pcv <= 16'h1234;
    @(posedge clock);
    pcld <= 1'b0;
    @(posedge clock);
    adv <= 1'b0;
    @(negedge clock);
    `CHK(pc, 16'h1235)
    rd(8'h55, 8'h00);
  endtask : t_pc

  task automatic t_port;
    wr(8'h91, 8'h0f);
    wr(8'h90, 8'ha5);
    `CHK(pin_out[7:0], 8'ha5)
    `CHK(pin_oe[7:0], 8'hf0)
    rd(8'h90, 8'hac);
    wr(8'ha1, 8'h00);
    wr(8'ha0, 8'h00);
    `CHK({pin_oe[8], pin_out[8]}, 2'b10)
    @(posedge clock);
    claim <= 9'h100;
    repeat (2) @(posedge clock);
    claim <= 9'h000;
    @(negedge clock);
    `CHK(pin_oe, 9'h0f0)
    wr(8'ha1, 8'h01);
    // Let the pin settle through the synchroniser
    repeat (4) @(posedge clock);
    rd(8'ha0, 8'h01);
  endtask : t_port

  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    t_reset();
    t_stack();
    t_flags();
    t_pointer();
    t_pc();
    t_port();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
